// >>> verilog/amc_consts.vh
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH

// Clock rate of sys_clk_in
`define AMC_CLK_MHZ        250

// Level-control timing, figures in their own units
`define AMC_ATK_BASE_US    32
`define AMC_ATK_FIX_US     256
`define AMC_HOLD_MIN_MS    90
`define AMC_HOLD_MAX_MS    120
`define AMC_REL_BASE_MS    4
`define AMC_REL_FIX_MS     128
`define AMC_US_PER_MS      1000

// Derived cycle counts
`define AMC_ATK_BASE_CYC   (`AMC_ATK_BASE_US * `AMC_CLK_MHZ)
`define AMC_ATK_FIX_CYC    (`AMC_ATK_FIX_US * `AMC_CLK_MHZ)
`define AMC_HOLD_CYC       (`AMC_HOLD_MIN_MS * `AMC_US_PER_MS * `AMC_CLK_MHZ)
`define AMC_REL_BASE_CYC   (`AMC_REL_BASE_MS * `AMC_US_PER_MS * `AMC_CLK_MHZ)
`define AMC_REL_FIX_CYC    (`AMC_REL_FIX_MS * `AMC_US_PER_MS * `AMC_CLK_MHZ)

// Gain codes, 0.5 dB per code, code 0 is 1 dB
`define AMC_GAIN_W         6
`define AMC_GAIN_FLOOR     6'h00
`define AMC_GAIN_MAX       6'h2F
`define AMC_GAIN_6DB       6'h0A
`define AMC_GAIN_12DB      6'h16
`define AMC_GAIN_18DB      6'h22
`define AMC_GAIN_24DB      6'h2E
`define AMC_GAIN_RST       6'h0A

// Latched operating mode, one-hot
`define AMC_MODE_NONE      3'h0
`define AMC_MODE_SER       3'h1
`define AMC_MODE_GSEL      3'h2
`define AMC_MODE_ALC       3'h4

// Mixer field positions of mode_control_reg
`define AMC_MIX_L2B_BIT    0
`define AMC_MIX_R2B_BIT    1

// Compression: two cuts, then one skipped tick; and mode capture cycle
`define AMC_COMP_SKIP_PH   2'h2
`define AMC_CAP_CYC        2'h2

`endif

// >>> verilog/amc_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for inputs from outside the clock domain
module amc_sync #(
  parameter W = 1
) (
  input  wire         sys_clk_in,
  input  wire         rst_in,
  input  wire         clk_en_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta_r;  // First stage, read only by the second

  // Plain double flop; nothing else may look at meta_r
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= {W{1'b0}};
      q_out  <= {W{1'b0}};
    end else if (clk_en_in) begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// >>> verilog/amc_timer.v
`timescale 1ns/1ps
// Interval counter: start loads the period, tick pulses at each expiry
module amc_timer (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire        clk_en_in,
  input  wire        start_in,
  input  wire        stop_in,
  input  wire [31:0] period_in,
  output reg         tick_out
);
  reg [31:0] cnt_r;  // Cycles left in the current interval
  reg        run_r;  // Counting

  // Start wins over stop so a restart is never lost
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r    <= 32'h0000_0000;
      run_r    <= 1'b0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      tick_out <= 1'b0;
      if (start_in) begin
        // A zero period would never expire; treat it as one cycle
        cnt_r <= (period_in == 32'h0000_0000) ? 32'h0000_0000 : period_in - 32'h0000_0001;
        run_r <= 1'b1;
      end else if (stop_in) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        if (cnt_r == 32'h0000_0000) begin
          // Periodic: reload for the next step
          tick_out <= 1'b1;
          cnt_r    <= (period_in == 32'h0000_0000) ? 32'h0000_0000 : period_in - 32'h0000_0001;
        end else begin
          cnt_r <= cnt_r - 32'h0000_0001;
        end
      end
    end
  end
endmodule

// >>> verilog/amc_top.v
`timescale 1ns/1ps
`include "amc_consts.vh"
// Function
// - Strap low: serial mode, pins are two-wire
// - Strap high: gain select, no bus, no ALC
// - Gain pins map to 6/12/18/24 dB
// - Strap floating: ALC mode, pins edge/threshold
// - ALC mode presets 18 dB, ALC always on
// - ALC mode: edge pin enables emission limiting
// - ALC mode: fixed 256 us, hold, 128 ms
// - Serial, ALC off: independent 48-step channel gains
// - Serial: sixteen threshold levels selectable
// - Serial: optional fixed-power threshold mode
// - Serial: four selectable edge-rate settings
// - Serial: route left or right to both
// - ALC enabled: ignore gain writes, left gain both
// - Below threshold keep preset; floor is 1 dB
// - Medium level: compress, two cuts per three
// - Large level: limit every step, stop at 1 dB
// - Attack fast, hold, then release gradually
// - Serial attack 32us-4ms, release 4-512ms steps
// - Mixer choice from mode control bits 0, 1
// - Soft knee off: limiter only
// - Level control changes gain in 0.5 dB steps, paced
module amc_top #(
  parameter [31:0] ATK_BASE_CYC = `AMC_ATK_BASE_CYC,
  parameter [31:0] ATK_FIX_CYC  = `AMC_ATK_FIX_CYC,
  parameter [31:0] HOLD_CYC     = `AMC_HOLD_CYC,
  parameter [31:0] REL_BASE_CYC = `AMC_REL_BASE_CYC,
  parameter [31:0] REL_FIX_CYC  = `AMC_REL_FIX_CYC
) (
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire       clk_en_in,
  input  wire       mode_strap_level_in,
  input  wire       mode_strap_float_in,
  input  wire       pin_c3_in,
  input  wire       pin_c4_in,
  output reg        pin_c4_out,
  output reg        pin_c4_oe_out,
  input  wire       twi_sda_low_in,
  input  wire       over_knee_in,
  input  wire       over_limit_in,
  input  wire       gain_wr_left_in,
  input  wire       gain_wr_right_in,
  input  wire [5:0] gain_wdata_in,
  input  wire       level_ctrl_on_in,
  input  wire       knee_en_in,
  input  wire [2:0] attack_sel_in,
  input  wire [2:0] release_sel_in,
  input  wire [3:0] thresh_sel_in,
  input  wire       fixed_power_in,
  input  wire [1:0] edge_rate_in,
  input  wire [1:0] mode_control_reg_in,
  output reg  [2:0] mode_out,
  output reg        twi_enable_out,
  output reg        twi_scl_out,
  output reg        twi_scl_rise_out,
  output reg        twi_sda_out,
  output reg  [5:0] left_gain_out,
  output reg  [5:0] right_gain_out,
  output reg        alc_active_out,
  output reg        alc_reducing_out,
  output reg        emi_limit_on_out,
  output reg  [1:0] edge_rate_out,
  output reg  [3:0] thresh_level_out,
  output reg        thresh_ext_out,
  output reg        fixed_power_out,
  output reg        route_left_both_out,
  output reg        route_right_both_out
);
  // Level-control states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ATK  = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_REL  = 4'h8;

  // Strap decode: float wins, then level
  function [2:0] amc_strap_mode;
    input flt;
    input lvl;
    begin
      if (flt)
        amc_strap_mode = `AMC_MODE_ALC;
      else if (lvl)
        amc_strap_mode = `AMC_MODE_GSEL;
      else
        amc_strap_mode = `AMC_MODE_SER;
    end
  endfunction

  // Gain select pins to gain code
  function [5:0] amc_gsel_gain;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    amc_gsel_gain = `AMC_GAIN_6DB;
        2'h1:    amc_gsel_gain = `AMC_GAIN_12DB;
        2'h2:    amc_gsel_gain = `AMC_GAIN_18DB;
        default: amc_gsel_gain = `AMC_GAIN_24DB;
      endcase
    end
  endfunction

  wire [1:0]  strap_s;       // Synchronised strap
  wire [3:0]  pin_s;         // c3, c4, knee, limit synchronised
  wire        c3_s;          // Shared pin C3
  wire        c4_s;          // Shared pin C4
  wire        knee_s;        // Compression comparator
  wire        limit_s;       // Limiting comparator
  reg  [1:0]  cap_cnt_r;     // Cycles since reset release
  reg  [2:0]  mode_r;        // Latched operating mode
  reg  [5:0]  left_gain_r;   // left_gain_reg contents
  reg  [5:0]  right_gain_r;  // right_gain_reg contents
  reg  [3:0]  st_r;          // Level-control state
  reg  [3:0]  st_nxt;
  reg  [5:0]  alc_gain_r;    // Level-control gain
  reg  [5:0]  alc_gain_nxt;
  reg  [1:0]  ph_r;          // Compression phase
  reg  [1:0]  ph_nxt;
  reg         step_start;    // Restart the step timer
  reg         hold_start;    // Start the hold timer
  reg         scl_d_r;       // Previous clock pin level
  wire        step_tick;     // One step period elapsed
  wire        hold_tick;     // Hold period elapsed
  wire        mode_ser;
  wire        mode_alc;
  wire        mode_gsel;
  wire        alc_on;        // Level control running
  wire        knee_on;       // Compression region allowed
  wire        over;          // Output above a threshold
  wire [5:0]  preset;        // Gain to rest at
  wire [5:0]  wr_gain;       // Write data clamped to 48 steps
  wire [31:0] atk_per;
  wire [31:0] rel_per;

  // Strap and pins cross into the clock domain first
  amc_sync #(.W(2)) u_strap_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .d_in       ({mode_strap_float_in, mode_strap_level_in}),
    .q_out      (strap_s)
  );

  amc_sync #(.W(4)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .d_in       ({pin_c3_in, pin_c4_in, over_knee_in, over_limit_in}),
    .q_out      (pin_s)
  );

  assign c3_s    = pin_s[3];
  assign c4_s    = pin_s[2];
  assign knee_s  = pin_s[1];
  assign limit_s = pin_s[0];

  assign mode_ser  = (mode_r == `AMC_MODE_SER);
  assign mode_alc  = (mode_r == `AMC_MODE_ALC);
  assign mode_gsel = (mode_r == `AMC_MODE_GSEL);

  // ALC mode forces level control on; gain select forces it off
  assign alc_on  = mode_alc | (mode_ser & level_ctrl_on_in);
  assign preset  = mode_alc ? `AMC_GAIN_18DB : left_gain_r;
  assign knee_on = mode_alc | knee_en_in;
  assign over    = limit_s | (knee_on & knee_s);
  assign wr_gain = (gain_wdata_in > `AMC_GAIN_MAX) ? `AMC_GAIN_MAX : gain_wdata_in;

  // Step periods: fixed in ALC mode, doubled per select code in serial mode
  assign atk_per = mode_alc ? ATK_FIX_CYC : (ATK_BASE_CYC << attack_sel_in);
  assign rel_per = mode_alc ? REL_FIX_CYC : (REL_BASE_CYC << release_sel_in);

  // Mode is caught once the strap has crossed both flops, then frozen
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_cnt_r <= 2'h0;
      mode_r    <= `AMC_MODE_NONE;
    end else if (clk_en_in) begin
      if (cap_cnt_r != 2'h3)
        cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == `AMC_CAP_CYC)
        mode_r <= amc_strap_mode(strap_s[1], strap_s[0]);
    end
  end

  // Channel gain registers; writes drop while level control owns gain
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      left_gain_r  <= `AMC_GAIN_RST;
      right_gain_r <= `AMC_GAIN_RST;
    end else if (clk_en_in) begin
      if (mode_ser & ~level_ctrl_on_in) begin
        if (gain_wr_left_in)
          left_gain_r <= wr_gain;
        if (gain_wr_right_in)
          right_gain_r <= wr_gain;
      end
    end
  end

  // Level-control next state: attack, hold, release around the preset
  always @* begin
    st_nxt       = st_r;
    alc_gain_nxt = alc_gain_r;
    ph_nxt       = ph_r;
    step_start   = 1'b0;
    hold_start   = 1'b0;
    if (!alc_on) begin
      // Idle controller tracks the preset so enabling starts clean
      st_nxt       = ST_IDLE;
      alc_gain_nxt = preset;
      ph_nxt       = 2'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          alc_gain_nxt = preset;
          if (over) begin
            st_nxt     = ST_ATK;
            step_start = 1'b1;
            ph_nxt     = 2'h0;
          end
        end
        ST_ATK: begin
          if (step_tick) begin
            if (over) begin
              // Limiting cuts every step; compression skips one in three
              if ((limit_s | (ph_r != `AMC_COMP_SKIP_PH)) &&
                  (alc_gain_r > `AMC_GAIN_FLOOR))
                alc_gain_nxt = alc_gain_r - 6'h01;
              ph_nxt = (limit_s | (ph_r == `AMC_COMP_SKIP_PH)) ? 2'h0 : ph_r + 2'h1;
            end else begin
              st_nxt     = ST_HOLD;
              hold_start = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (over) begin
            st_nxt     = ST_ATK;
            step_start = 1'b1;
            ph_nxt     = 2'h0;
          end else if (hold_tick) begin
            st_nxt     = ST_REL;
            step_start = 1'b1;
          end
        end
        ST_REL: begin
          if (over) begin
            st_nxt     = ST_ATK;
            step_start = 1'b1;
            ph_nxt     = 2'h0;
          end else if (alc_gain_r >= preset) begin
            st_nxt       = ST_IDLE;
            alc_gain_nxt = preset;
          end else if (step_tick) begin
            alc_gain_nxt = alc_gain_r + 6'h01;
          end
        end
        default: begin
          st_nxt       = ST_IDLE;
          alc_gain_nxt = preset;
        end
      endcase
    end
  end

  // Level-control state registers
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r       <= ST_IDLE;
      alc_gain_r <= `AMC_GAIN_FLOOR;
      ph_r       <= 2'h0;
    end else if (clk_en_in) begin
      st_r       <= st_nxt;
      alc_gain_r <= alc_gain_nxt;
      ph_r       <= ph_nxt;
    end
  end

  // Step pace; the period follows the state being entered
  amc_timer u_step_tmr (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .start_in   (step_start),
    .stop_in    ((st_nxt == ST_IDLE) | (st_nxt == ST_HOLD)),
    .period_in  ((st_nxt == ST_ATK) ? atk_per : rel_per),
    .tick_out   (step_tick)
  );

  // Hold interval; fixed in every mode
  amc_timer u_hold_tmr (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .start_in   (hold_start),
    .stop_in    (st_r != ST_HOLD),
    .period_in  (HOLD_CYC),
    .tick_out   (hold_tick)
  );

  // Registered outputs, steered by the latched mode
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_out             <= `AMC_MODE_NONE;
      twi_enable_out       <= 1'b0;
      twi_scl_out          <= 1'b0;
      twi_scl_rise_out     <= 1'b0;
      twi_sda_out          <= 1'b0;
      pin_c4_out           <= 1'b0;
      pin_c4_oe_out        <= 1'b0;
      scl_d_r              <= 1'b0;
      left_gain_out        <= `AMC_GAIN_FLOOR;
      right_gain_out       <= `AMC_GAIN_FLOOR;
      alc_active_out       <= 1'b0;
      alc_reducing_out     <= 1'b0;
      emi_limit_on_out     <= 1'b0;
      edge_rate_out        <= 2'h0;
      thresh_level_out     <= 4'h0;
      thresh_ext_out       <= 1'b0;
      fixed_power_out      <= 1'b0;
      route_left_both_out  <= 1'b0;
      route_right_both_out <= 1'b0;
    end else if (clk_en_in) begin
      mode_out <= mode_r;
      // Two-wire pins only in serial mode; data line is open drain
      scl_d_r          <= c3_s;
      twi_enable_out   <= mode_ser;
      twi_scl_out      <= mode_ser & c3_s;
      twi_scl_rise_out <= mode_ser & c3_s & ~scl_d_r;
      twi_sda_out      <= mode_ser & c4_s;
      pin_c4_out       <= 1'b0;
      pin_c4_oe_out    <= mode_ser & twi_sda_low_in;
      alc_active_out   <= alc_on;
      alc_reducing_out <= alc_on & (st_r == ST_ATK);
      // Gain path
      if (mode_gsel) begin
        left_gain_out  <= amc_gsel_gain({c4_s, c3_s});
        right_gain_out <= amc_gsel_gain({c4_s, c3_s});
      end else if (alc_on) begin
        left_gain_out  <= alc_gain_r;
        right_gain_out <= alc_gain_r;
      end else if (mode_ser) begin
        left_gain_out  <= left_gain_r;
        right_gain_out <= right_gain_r;
      end else begin
        left_gain_out  <= `AMC_GAIN_FLOOR;
        right_gain_out <= `AMC_GAIN_FLOOR;
      end
      // Emission control: pin in ALC mode, field in serial, off otherwise
      if (mode_alc) begin
        emi_limit_on_out <= c3_s;
        edge_rate_out    <= c3_s ? 2'h3 : 2'h0;
      end else if (mode_ser) begin
        emi_limit_on_out <= (edge_rate_in != 2'h0);
        edge_rate_out    <= edge_rate_in;
      end else begin
        emi_limit_on_out <= 1'b0;
        edge_rate_out    <= 2'h0;
      end
      // Threshold source: resistor pin in ALC mode, field in serial
      thresh_ext_out       <= mode_alc;
      thresh_level_out     <= mode_ser ? thresh_sel_in : 4'h0;
      fixed_power_out      <= mode_ser & fixed_power_in;
      route_left_both_out  <= mode_ser & mode_control_reg_in[`AMC_MIX_L2B_BIT];
      route_right_both_out <= mode_ser & mode_control_reg_in[`AMC_MIX_R2B_BIT];
    end
  end
endmodule

// >>> tb/amc_board_model.sv
`timescale 1ns/1ps
// Board straps plus a two-wire host on the shared pins
module amc_board_model (
  input  wire logic pin_c4_oe_in,    // Device pulls data low
  output logic      strap_level_out, // Strap tied high
  output logic      strap_float_out, // Strap left open
  output logic      pin_c3_out,      // Link clock or strap level
  output wire logic pin_c4_out       // Resolved data or strap level
);
  logic od_mode_r = 1'b1;  // C4 acts as open-drain data
  logic c4_hi_r   = 1'b0;  // C4 strap level outside serial mode
  logic host_low_r = 1'b0; // Host pulls data low
  // Pull-up wins unless some party pulls low
  assign pin_c4_out = od_mode_r ? !(host_low_r || pin_c4_oe_in) : c4_hi_r;
  initial begin
    strap_level_out = 1'b0;
    strap_float_out = 1'b0;
    pin_c3_out = 1'b1;
  end
  // Strap choice; open-drain data only when tied low
  task automatic set_strap(input logic lvl, input logic flt);
    strap_level_out = lvl;
    strap_float_out = flt;
    od_mode_r = !lvl && !flt;
  endtask
  // Static pin levels for gain select or emission pin
  task automatic set_pins(input logic c3, input logic c4);
    pin_c3_out = c3;
    c4_hi_r = c4;
  endtask
  // Link clock runs only inside a burst, idles high
  task automatic clocks(input int n);
    for (int k = 0; k < n; k++) begin
      #32 pin_c3_out = 1'b0;
      #32 pin_c3_out = 1'b1;
    end
  endtask
endmodule

// >>> tb/amc_top_assertions.sv
`timescale 1ns/1ps
`include "amc_consts.vh"
// Port-level checks on the amplifier control top
module amc_top_assertions (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic [1:0] mode_control_reg_in,
  input wire logic       pin_c4_out,
  input wire logic       pin_c4_oe_out,
  input wire logic [2:0] mode_out,
  input wire logic       twi_enable_out,
  input wire logic       twi_scl_out,
  input wire logic       twi_scl_rise_out,
  input wire logic [5:0] left_gain_out,
  input wire logic [5:0] right_gain_out,
  input wire logic       alc_active_out,
  input wire logic       emi_limit_on_out,
  input wire logic       route_left_both_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Mode settled long enough for registered outputs to follow
  sequence s_ser;  mode_out == `AMC_MODE_SER [*3];  endsequence
  sequence s_gsel; mode_out == `AMC_MODE_GSEL [*3]; endsequence
  sequence s_alc;  mode_out == `AMC_MODE_ALC [*3];  endsequence
  // A rise pulse sits on a high clock and lasts one cycle
  sequence s_rise_tail; twi_scl_out ##1 !twi_scl_rise_out; endsequence
  AST_MODE_HELD: assert property (mode_out != `AMC_MODE_NONE |=> $stable(mode_out))
    else $error("mode changed after latch");
  AST_SER_TWI: assert property (s_ser |-> twi_enable_out)
    else $error("serial mode without two-wire enable");
  AST_GSEL_OFF: assert property (s_gsel |-> !twi_enable_out && !alc_active_out && !emi_limit_on_out)
    else $error("gain select left a feature on");
  AST_ALC_ON: assert property (s_alc |-> alc_active_out && !twi_enable_out)
    else $error("level mode state wrong");
  AST_ALC_CEIL: assert property (s_alc ##1 1'b1 |-> left_gain_out <= `AMC_GAIN_18DB)
    else $error("gain above preset");
  AST_ALC_SAME: assert property (s_alc ##1 1'b1 |-> right_gain_out == left_gain_out)
    else $error("channels differ in level mode");
  AST_HALF_STEP: assert property (s_alc ##2 $changed(left_gain_out) |->
    (left_gain_out + 6'h01 == $past(left_gain_out)) ||
    (left_gain_out == $past(left_gain_out) + 6'h01))
    else $error("gain moved by more than one code");
  AST_ROUTE: assert property (s_ser ##0 mode_control_reg_in[`AMC_MIX_L2B_BIT] [*3]
    |-> route_left_both_out)
    else $error("left routing not applied");
  AST_OD_LOW: assert property (!pin_c4_out && (!pin_c4_oe_out || mode_out == `AMC_MODE_SER))
    else $error("data pin driven outside serial mode");
  AST_RISE: assert property (twi_scl_rise_out |-> s_rise_tail)
    else $error("clock rise pulse malformed");
endmodule
bind amc_top amc_top_assertions amc_top_assertions_i (.sys_clk_in, .rst_in,
  .mode_control_reg_in, .pin_c4_out, .pin_c4_oe_out, .mode_out, .twi_enable_out,
  .twi_scl_out, .twi_scl_rise_out, .left_gain_out, .right_gain_out, .alc_active_out,
  .emi_limit_on_out, .route_left_both_out);

// >>> tb/amc_top_tb.sv
`timescale 1ns/1ps
`include "amc_consts.vh"
// Self-checking bench for mode decode and level control
module amc_top_tb;
  logic       sys_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       twi_sda_low_in = 1'b0;
  logic       over_knee_in = 1'b0;
  logic       over_limit_in = 1'b0;
  logic       gain_wr_left_in = 1'b0;
  logic       gain_wr_right_in = 1'b0;
  logic [5:0] gain_wdata_in = 6'h00;
  logic       level_ctrl_on_in = 1'b0;
  logic       knee_en_in = 1'b1;
  logic [2:0] attack_sel_in = 3'h0;
  logic [2:0] release_sel_in = 3'h0;
  logic [3:0] thresh_sel_in = 4'h0;
  logic       fixed_power_in = 1'b0;
  logic [1:0] edge_rate_in = 2'h0;
  logic [1:0] mode_control_reg_in = 2'h0;
  wire        s_lvl, s_flt, c3, c4, c4_oe, twi_en, scl_rise, alc_act, emi, fix_o, rl, rr;
  wire  [2:0] mode;
  wire  [5:0] gl, gr;
  wire  [1:0] edge_o;
  wire  [3:0] thr_o;
  wire        scl, red, tx;
  int         n_fail = 0;
  int         check_count = 0;
  // 4 ns system clock
  always #2 sys_clk_in = ~sys_clk_in;
  // Short timer periods
  amc_top #(.ATK_BASE_CYC(8), .ATK_FIX_CYC(16), .HOLD_CYC(200), .REL_BASE_CYC(40),
    .REL_FIX_CYC(60)) amc_top_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .mode_strap_level_in(s_lvl), .mode_strap_float_in(s_flt), .pin_c3_in(c3), .pin_c4_in(c4),
    .pin_c4_out(), .pin_c4_oe_out(c4_oe), .twi_sda_low_in(twi_sda_low_in),
    .over_knee_in(over_knee_in), .over_limit_in(over_limit_in),
    .gain_wr_left_in(gain_wr_left_in), .gain_wr_right_in(gain_wr_right_in),
    .gain_wdata_in(gain_wdata_in), .level_ctrl_on_in(level_ctrl_on_in),
    .knee_en_in(knee_en_in), .attack_sel_in(attack_sel_in), .release_sel_in(release_sel_in),
    .thresh_sel_in(thresh_sel_in), .fixed_power_in(fixed_power_in),
    .edge_rate_in(edge_rate_in), .mode_control_reg_in(mode_control_reg_in), .mode_out(mode),
    .twi_enable_out(twi_en), .twi_scl_out(scl), .twi_scl_rise_out(scl_rise), .twi_sda_out(),
    .left_gain_out(gl), .right_gain_out(gr), .alc_active_out(alc_act),
    .alc_reducing_out(red), .emi_limit_on_out(emi), .edge_rate_out(edge_o),
    .thresh_level_out(thr_o), .thresh_ext_out(tx), .fixed_power_out(fix_o),
    .route_left_both_out(rl), .route_right_both_out(rr));
  amc_board_model amc_board_model_i (.pin_c4_oe_in(c4_oe), .strap_level_out(s_lvl),
    .strap_float_out(s_flt), .pin_c3_out(c3), .pin_c4_out(c4));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Cycles until the left gain moves; a stuck gain ends the run
  task automatic wait_step(input int lim, output int n);
    logic [5:0] start;
    start = gl;
    n = 0;
    while (gl === start) begin
      cyc(1);
      n++;
      if (n > lim) begin
        check("gain step wait", 8'h01, 8'h00);
        wrap_up();
      end
    end
  endtask
  // One-cycle write strobe; the leading edge keeps drives apart
  task automatic gwr(input logic l, input logic r, input logic [5:0] d);
    cyc(1);
    gain_wr_left_in = l;
    gain_wr_right_in = r;
    gain_wdata_in = d;
    cyc(1);
    gain_wr_left_in = 1'b0;
    gain_wr_right_in = 1'b0;
  endtask
  // Strap set before release
  task automatic do_reset(input logic lvl, input logic flt);
    amc_board_model_i.set_strap(lvl, flt);
    rst_in = 1'b1;
    cyc(12);
    rst_in = 1'b0;
    cyc(10);
  endtask
  task automatic t_serial();
    int n;
    do_reset(1'b0, 1'b0);
    check("mode", 8'(`AMC_MODE_SER), 8'(mode));
    check("twi enable", 8'h01, 8'(twi_en));
    gwr(1'b1, 1'b0, 6'h10);
    gwr(1'b0, 1'b1, 6'h05);
    cyc(3);
    check("left gain", 8'h10, 8'(gl));
    check("right gain", 8'h05, 8'(gr));
    gwr(1'b1, 1'b0, 6'h3F);
    cyc(3);
    check("left clamp", 8'(`AMC_GAIN_MAX), 8'(gl));
    level_ctrl_on_in = 1'b1;
    gwr(1'b1, 1'b1, 6'h01);
    cyc(3);
    check("left locked", 8'(`AMC_GAIN_MAX), 8'(gl));
    check("right from left", 8'(`AMC_GAIN_MAX), 8'(gr));
    level_ctrl_on_in = 1'b0;
    gwr(1'b1, 1'b1, 6'h07);
    cyc(3);
    check("both gains", 8'h07, 8'(gr));
    mode_control_reg_in = 2'h1;
    fixed_power_in = 1'b1;
    edge_rate_in = 2'h2;
    cyc(4);
    check("route left", 8'h01, 8'(rl));
    check("route right off", 8'h00, 8'(rr));
    check("fixed power", 8'h01, 8'(fix_o));
    check("edge rate", 8'h02, 8'(edge_o));
    check("emission on", 8'h01, 8'(emi));
    mode_control_reg_in = 2'h2;
    edge_rate_in = 2'h0;
    cyc(4);
    check("route right", 8'h01, 8'(rr));
    check("emission off", 8'h00, 8'(emi));
    for (int i = 0; i < 16; i++) begin
      thresh_sel_in = 4'(i);
      cyc(4);
      check("threshold", 8'(i), 8'(thr_o));
    end
    n = 0;
    fork
      amc_board_model_i.clocks(4);
      repeat (100) begin
        cyc(1);
        if (scl_rise === 1'b1) n++;
      end
    join
    check("clock rises", 8'h04, 8'(n));
    check("scl", 8'h01, 8'(scl));
    twi_sda_low_in = 1'b1;
    cyc(3);
    check("data pulled", 8'h00, 8'(c4));
    twi_sda_low_in = 1'b0;
    cyc(3);
    check("data released", 8'h01, 8'(c4));
    // Knee disabled: knee comparator alone must not cut
    level_ctrl_on_in = 1'b1;
    knee_en_in = 1'b0;
    over_knee_in = 1'b1;
    cyc(100);
    check("limiter only", 8'h07, 8'(gl));
    over_knee_in = 1'b0;
    attack_sel_in = 3'h1;
    over_limit_in = 1'b1;
    wait_step(100, n);
    wait_step(100, n);
    check("serial attack", 8'h10, 8'(n));
    check("reduce", 8'h01, 8'(red));
    over_limit_in = 1'b0;
  endtask
  task automatic t_gsel();
    logic [5:0] codes [4];
    codes = '{`AMC_GAIN_6DB, `AMC_GAIN_12DB, `AMC_GAIN_18DB, `AMC_GAIN_24DB};
    amc_board_model_i.set_pins(1'b0, 1'b0);
    do_reset(1'b1, 1'b0);
    check("mode", 8'(`AMC_MODE_GSEL), 8'(mode));
    for (int i = 0; i < 4; i++) begin
      amc_board_model_i.set_pins(i[0], i[1]);
      cyc(5);
      check("gsel left", 8'(codes[i]), 8'(gl));
      check("gsel right", 8'(codes[i]), 8'(gr));
    end
    check("gsel twi", 8'h00, 8'(twi_en));
    check("gsel level ctrl", 8'h00, 8'(alc_act));
    check("gsel emission", 8'h00, 8'(emi));
    amc_board_model_i.set_strap(1'b0, 1'b0);
    cyc(6);
    check("mode kept", 8'(`AMC_MODE_GSEL), 8'(mode));
  endtask
  task automatic t_alc();
    int n;
    logic [5:0] prev;
    amc_board_model_i.set_pins(1'b0, 1'b0);
    do_reset(1'b0, 1'b1);
    check("mode", 8'(`AMC_MODE_ALC), 8'(mode));
    check("alc twi", 8'h00, 8'(twi_en));
    check("ext thr", 8'h01, 8'(tx));
    check("alc active", 8'h01, 8'(alc_act));
    check("preset", 8'(`AMC_GAIN_18DB), 8'(gl));
    amc_board_model_i.set_pins(1'b1, 1'b0);
    cyc(5);
    check("edge pin on", 8'h01, 8'(emi));
    check("edge rate max", 8'h03, 8'(edge_o));
    amc_board_model_i.set_pins(1'b0, 1'b0);
    cyc(5);
    check("edge pin off", 8'h00, 8'(emi));
    over_limit_in = 1'b1;
    wait_step(100, n);
    wait_step(100, n);
    check("attack step", 8'h10, 8'(n));
    cyc(600);
    check("floor left", 8'(`AMC_GAIN_FLOOR), 8'(gl));
    check("floor right", 8'(`AMC_GAIN_FLOOR), 8'(gr));
    over_limit_in = 1'b0;
    cyc(200);
    check("hold", 8'(`AMC_GAIN_FLOOR), 8'(gl));
    wait_step(300, n);
    wait_step(100, n);
    check("release step", 8'h3C, 8'(n));
    cyc(2100);
    check("recovered", 8'(`AMC_GAIN_18DB), 8'(gl));
    over_knee_in = 1'b1;
    wait_step(100, n);
    n = 0;
    repeat (95) begin
      prev = gl;
      cyc(1);
      if (gl !== prev) n++;
    end
    check("knee cuts", 8'h03, 8'(n));
    over_knee_in = 1'b0;
  endtask
  initial begin
    t_serial();
    t_gsel();
    t_alc();
    wrap_up();
  end
endmodule
